// ### rtl/linear_breakpoint_unit.sv
// Breakpoint unit: debug registers, matching, exceptions, AXI4-Lite slave
`timescale 1ns/1ns
module linear_breakpoint_unit
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core side
  input wire bkpt_pkg::access_t acc,
  input wire bkpt_pkg::core_t core,
  output bkpt_pkg::excp_t excp,
  // AXI4-Lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic [3:0][31:0] target;
    logic [31:0] ctl;
    logic [31:0] sts;
    logic aw_held;
    logic [4:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic fault;
    logic trap;
    logic dbg_ack;
    logic dbg_denied;
    logic [31:0] dbg_rdata;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [3:0] exec_hit;
  logic [3:0] data_hit;
  logic [3:0] enabled;

  // Four identical comparators
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cmp
      bkpt_match u_match
      (
        .target(st_q.target[gi]),
        .size(st_q.ctl[bkpt_pkg::CTL_SIZE0 + 4*gi +: 2]),
        .acc_type(st_q.ctl[bkpt_pkg::CTL_TYPE0 + 4*gi +: 2]),
        .acc(acc),
        .exec_hit(exec_hit[gi]),
        .data_hit(data_hit[gi])
      );
      assign enabled[gi] = st_q.ctl[bkpt_pkg::CTL_LOCAL_EN0 + 2*gi]
        | st_q.ctl[bkpt_pkg::CTL_LOCAL_EN0 + 2*gi + 1];
    end
  endgenerate

  // Read mux shared by bus and core port
  function automatic logic [31:0] reg_read(input state_t s,
                                           input logic [2:0] idx);
    logic [31:0] v;
    v = 32'h0;
    if (idx < 3'h4)
      v = s.target[idx[1:0]];
    else if (idx == 3'h4)
      v = s.sts;
    else if (idx == 3'h5)
      v = s.ctl;
    return v;
  endfunction

  // Merge a write into one register, keeping unwritable bits
  function automatic state_t reg_write(input state_t s,
                                       input logic [2:0] idx,
                                       input logic [31:0] data,
                                       input logic [31:0] bmask);
    state_t r;
    r = s;
    if (idx < 3'h4)
      r.target[idx[1:0]] = (s.target[idx[1:0]] & ~bmask) | (data & bmask);
    else if (idx == 3'h4)
      r.sts = (s.sts & ~(bmask & bkpt_pkg::STS_WMASK))
        | (data & bmask & bkpt_pkg::STS_WMASK);
    else if (idx == 3'h5)
      r.ctl = (s.ctl & ~(bmask & bkpt_pkg::CTL_WMASK))
        | (data & bmask & bkpt_pkg::CTL_WMASK);
    return r;
  endfunction

  // Next state: bus slave, core port, then hardware events
  always_comb
  begin
    logic [31:0] bm;
    logic any_exec;
    logic any_data;
    logic step;
    logic guard_hit;
    bm = 32'h0;
    any_exec = 1'b0;
    any_data = 1'b0;
    step = 1'b0;
    guard_hit = 1'b0;
    st_d = st_q;
    st_d.fault = 1'b0;
    st_d.trap = 1'b0;
    st_d.dbg_ack = 1'b0;
    st_d.dbg_denied = 1'b0;

    // Bus write: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
    begin
      for (int b = 0; b < 4; b++)
        bm[8*b +: 8] = {8{st_q.w_strb[b]}};
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      if (st_q.aw_addr[1:0] != 2'h0 || st_q.aw_addr[4:2] > 3'h5)
        st_d.bresp = bkpt_pkg::RESP_SLVERR;
      else
      begin
        st_d.bresp = bkpt_pkg::RESP_OKAY;
        st_d = reg_write(st_d, st_q.aw_addr[4:2], st_q.w_data, bm);
      end
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;

    // Bus read, one at a time
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata = reg_read(st_q, s_axi_araddr[4:2]);
      st_d.rresp = (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[4:2] > 3'h5)
        ? bkpt_pkg::RESP_SLVERR : bkpt_pkg::RESP_OKAY;
    end
    else if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;

    // Core access to debug registers: privilege then guard
    if (core.dbg_req)
    begin
      if (!(core.real_mode || core.cpl == 2'h0))
        st_d.dbg_denied = 1'b1;
      else if (st_q.ctl[bkpt_pkg::CTL_GUARD])
        guard_hit = 1'b1;
      else
      begin
        st_d.dbg_ack = 1'b1;
        st_d.dbg_rdata = reg_read(st_q, core.dbg_sel);
        if (core.dbg_write)
          st_d = reg_write(st_d, core.dbg_sel, core.dbg_wdata,
                           32'hffff_ffff);
      end
    end

    // Task switch clears local enables and local exact only
    if (core.task_switch)
    begin
      for (int i = 0; i < 4; i++)
        st_d.ctl[bkpt_pkg::CTL_LOCAL_EN0 + 2*i] = 1'b0;
      st_d.ctl[bkpt_pkg::CTL_LOCAL_EXACT] = 1'b0;
    end

    // Hit detection; here flags are only ever set, never cleared
    any_exec = |(exec_hit & enabled);
    any_data = |(data_hit & enabled);
    step = core.insn_end && core.flags[bkpt_pkg::FLAGS_STEP_BIT];
    if (any_exec || any_data)
      st_d.sts[3:0] = st_d.sts[3:0] | exec_hit | data_hit;
    if (guard_hit)
      st_d.sts[bkpt_pkg::STS_REG_ACCESS] = 1'b1;
    if (step)
      st_d.sts[bkpt_pkg::STS_SINGLE_STEP] = 1'b1;
    if (core.task_switch && core.task_trap_attr)
      st_d.sts[bkpt_pkg::STS_TASK_SWITCH] = 1'b1;

    // Fault before execution, trap after transfer, single step or switch
    st_d.fault = any_exec || guard_hit;
    st_d.trap = any_data || step
      || (core.task_switch && core.task_trap_attr);

    // Handler entry frees the registers for the handler
    if (core.handler_entry || guard_hit)
      st_d.ctl[bkpt_pkg::CTL_GUARD] = 1'b0;
  end

  // State register; reset leaves every breakpoint disabled
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.ctl <= bkpt_pkg::CTL_RESET;
      st_q.sts <= bkpt_pkg::STS_RESET;
      st_q.target <= {4{bkpt_pkg::TARGET_RESET}};
    end
    else
      st_q <= st_d;
  end

  // Handshakes and data all driven from flip-flops
  assign s_axi_awready = !st_q.aw_held;
  assign s_axi_wready = !st_q.w_held;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign excp.fault = st_q.fault;
  assign excp.trap = st_q.trap;
  assign excp.dbg_ack = st_q.dbg_ack;
  assign excp.dbg_denied = st_q.dbg_denied;
  assign excp.dbg_rdata = st_q.dbg_rdata;
endmodule

// ### common/bkpt_pkg.sv
// Package: register map, field layout and carrier types of the breakpoint unit
// Behaviour
// - Four 32-bit targets, compared with every software linear address.
// - Compare linear addresses before page translation, paging on or off.
// - Size field 00 one byte, 01 two bytes, 11 four bytes, aligned.
// - Access field 00 execute, 01 data write, 11 data read or write.
// - Execution hit is a fault before; data hit a trap after transfer.
// - Data hit when any accessed byte overlaps the aligned field.
// - Execution breakpoints: size and access 00, match first insn byte.
// - Debug register access allowed only in real mode or privilege 0.
// - Guard bit set turns any debug register access into a debug fault; the code faults only privileged accesses, unprivileged ones are denied.
// - Guard bit clears automatically on entry to the debug handler.
// - Data hits always exact; execution waits for operand transfers.
// - Task switch clears local exact bit, keeps global exact bit.
// - Enabled if global or local enable set; a hit calls the handler.
// - Task switch clears all four local enables, keeps global enables.
// - Hardware only sets status flags; handler software clears them.
// - On any enabled hit, set match flags of all matching breakpoints.
// - Register-access flag set when a guarded access faulted.
// - Single-step status flag set when single-step caused the exception.
// - Task switch with trap attribute completes, sets flag, then traps.
// - After reset all breakpoints are disabled.
// - Single-step flag (bit 8) at instruction end raises a debug trap.
// - Resume flag suppresses the execution hit at the return address.
package bkpt_pkg;
  // Register byte offsets on the bus
  localparam logic [4:0] OFF_TARGET0 = 5'h00;
  localparam logic [4:0] OFF_TARGET1 = 5'h04;
  localparam logic [4:0] OFF_TARGET2 = 5'h08;
  localparam logic [4:0] OFF_TARGET3 = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_CONTROL = 5'h14;
  // Control field positions
  localparam int CTL_LOCAL_EN0 = 0;
  localparam int CTL_LOCAL_EXACT = 8;
  localparam int CTL_GLOBAL_EXACT = 9;
  localparam int CTL_GUARD = 13;
  localparam int CTL_TYPE0 = 16;
  localparam int CTL_SIZE0 = 18;
  // Status field positions
  localparam int STS_REG_ACCESS = 13;
  localparam int STS_SINGLE_STEP = 14;
  localparam int STS_TASK_SWITCH = 15;
  // Writable bits and reset values
  localparam logic [31:0] CTL_WMASK = 32'hffff_23ff;
  localparam logic [31:0] STS_WMASK = 32'h0000_e00f;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] STS_RESET = 32'h0000_0000;
  localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
  // Encodings
  localparam logic [1:0] TYPE_EXEC = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_RDWR = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FLAGS_STEP_BIT = 8;

  // Linear access offered by the core each cycle
  typedef struct packed {
    logic fetch_valid;
    logic [31:0] fetch_addr;
    logic resume_flag;
    logic data_done;
    logic data_write;
    logic [31:0] data_addr;
    logic [3:0] data_bytes;
  } access_t;

  // Core events and privileged register port
  typedef struct packed {
    logic insn_end;
    logic [31:0] flags;
    logic task_switch;
    logic task_trap_attr;
    logic handler_entry;
    logic dbg_req;
    logic dbg_write;
    logic [2:0] dbg_sel;
    logic [31:0] dbg_wdata;
    logic real_mode;
    logic [1:0] cpl;
  } core_t;

  // Exception requests back to the core
  typedef struct packed {
    logic fault;
    logic trap;
    logic dbg_ack;
    logic dbg_denied;
    logic [31:0] dbg_rdata;
  } excp_t;
endpackage

// ### rtl/bkpt_match.sv
// One breakpoint comparator: execution and data overlap match
`timescale 1ns/1ns
module bkpt_match
(
  // Breakpoint setup
  input wire logic [31:0] target,
  input wire logic [1:0] size,
  input wire logic [1:0] acc_type,
  // Linear accesses
  input wire bkpt_pkg::access_t acc,
  // Results
  output logic exec_hit,
  output logic data_hit
);
  logic [31:0] mask;
  logic [31:0] dend;
  logic [31:0] bend;

  // Field mask aligns the target; no page translation sits in front
  always_comb
  begin
    unique case (size)
      bkpt_pkg::SIZE_WORD: mask = 32'hffff_fffe;
      bkpt_pkg::SIZE_DWORD: mask = 32'hffff_fffc;
      default: mask = 32'hffff_ffff;
    endcase
  end

  // Inclusive end addresses of access and field, for overlap
  assign dend = acc.data_addr + {28'h0, acc.data_bytes} - 32'h1;
  assign bend = (target & mask) | ~mask;

  // Exact first-byte compare; resume flag masks the returning fetch
  assign exec_hit = acc.fetch_valid && !acc.resume_flag
    && acc_type == bkpt_pkg::TYPE_EXEC
    && acc.fetch_addr == target;

  // Any byte overlapping the field counts
  assign data_hit = acc.data_done && acc.data_bytes != 4'h0
    && (acc_type == bkpt_pkg::TYPE_RDWR
      || (acc_type == bkpt_pkg::TYPE_WRITE && acc.data_write))
    && acc.data_addr <= bend
    && dend >= (target & mask);
endmodule

// ### dv/bkpt_asserts.sv
// Port checker of the breakpoint unit
`timescale 1ns/1ns
module bkpt_asserts
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core side
  input wire bkpt_pkg::access_t acc,
  input wire bkpt_pkg::core_t core,
  input wire bkpt_pkg::excp_t excp,
  // Read channel
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_arready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Exceptions tied to their causes one cycle earlier
  AST_RST: assert property ($past(rst) |-> !excp.fault)
    else $error("fault after reset");
  AST_STEP: assert property (core.insn_end && core.flags[8]
    |=> excp.trap) else $error("no step trap");
  AST_TASK: assert property (core.task_switch && core.task_trap_attr
    |=> excp.trap) else $error("no task trap");
  AST_DENY: assert property (core.dbg_req && !core.real_mode
    && |core.cpl |=> excp.dbg_denied && !excp.dbg_ack)
    else $error("no denial");
  AST_RESUME: assert property (acc.resume_flag && !core.dbg_req
    |=> !excp.fault) else $error("fault under resume");
  AST_NOFAULT: assert property (!acc.fetch_valid && !core.dbg_req
    |=> !excp.fault) else $error("fault without cause");
  AST_NOTRAP: assert property (!acc.data_done && !core.insn_end
    && !core.task_switch |=> !excp.trap) else $error("trap without cause");
  // Read handshake keeps its answer
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && !s_axi_arready) else $error("rvalid dropped");
endmodule
bind linear_breakpoint_unit bkpt_asserts bkpt_asserts_inst (.clk_sys(clk_sys),
  .rst(rst), .acc(acc), .core(core), .excp(excp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready));

// ### dv/core_model.sv
// Core-side partner driving accesses and events
`timescale 1ns/1ns
module core_model
(
  // Clock
  input wire logic clk_sys,
  // Toward the unit
  output bkpt_pkg::access_t acc,
  output bkpt_pkg::core_t core,
  // From the unit
  input wire bkpt_pkg::excp_t excp
);
  // Quiet privileged core at time zero
  initial
  begin
    acc = '0;
    core = '0;
    core.real_mode = 1'b1;
  end
  // One-cycle request, answer read one cycle later
  task automatic step(input bkpt_pkg::access_t a, input bkpt_pkg::core_t c,
    output bkpt_pkg::excp_t e);
    @(posedge clk_sys);
    acc <= a;
    core <= c;
    @(posedge clk_sys);
    // Strobes cleared and stale addresses and write data inverted so they never look valid
    acc <= '{1'b0, ~a.fetch_addr, 1'b0, 1'b0, 1'b0, ~a.data_addr, 4'h0};
    core <= '{1'b0, c.flags, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0,
      ~c.dbg_wdata, c.real_mode, c.cpl};
    #1 e = excp;
  endtask
endmodule

// ### dv/tb_linear_breakpoint_unit.sv
// Self-checking bench of the breakpoint unit
`timescale 1ns/1ns
module tb_linear_breakpoint_unit;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  bkpt_pkg::access_t acc, a;
  bkpt_pkg::core_t core, c, ci;
  bkpt_pkg::excp_t excp, e;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr, bv, arr, rv;
  int err_total = 0, total_checks = 0, ctl, i, k, t, s, hits, en, ex, w, ad;
  int tgt [4];
  int tc [3] = '{0, 1, 3};
  // Clock
  always #10 clk_sys = ~clk_sys;
  // Unit and its core partner
  linear_breakpoint_unit linear_breakpoint_unit_inst (.clk_sys(clk_sys),
    .rst(rst), .acc(acc), .core(core), .excp(excp), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  core_model core_model_inst (.clk_sys(clk_sys), .acc(acc), .core(core),
    .excp(excp));
  // Comparison and verdict
  task automatic chk(input string n, input logic [31:0] x,
    input logic [31:0] y);
    total_checks++;
    if (x !== y)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, y, x);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic hang();
    err_total++;
    give_verdict();
  endtask
  // Bus write; each channel dropped once taken
  task automatic wr32(input logic [4:0] ax, input logic [31:0] dt);
    int n;
    @(posedge clk_sys);
    awaddr <= ax;
    wdata <= dt;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 40 && !bv; n++)
    begin
      @(posedge clk_sys);
      awv <= awv && !awr;
      wv <= wv && !wr;
    end
    r = bresp;
    br <= 1'b0;
    if (n == 40)
      hang();
  endtask
  // Bus read; rready only follows rvalid, so the answer must be held
  task automatic rd32(input logic [4:0] ax);
    int n;
    @(posedge clk_sys);
    araddr <= ax;
    arv <= 1'b1;
    for (n = 0; n < 40 && !(rv && rr); n++)
    begin
      @(posedge clk_sys);
      arv <= arv && !arr;
      rr <= rv && !rr;
    end
    d = rdata;
    r = rresp;
    if (n == 40)
      hang();
  endtask
  // Reference match: aligned field overlap or exact first byte
  function automatic bit mhit(int j);
    int ty = ctl >> 16 + 4 * j & 3;
    int sz = ctl >> 18 + 4 * j & 3;
    int lo = tgt[j] & ~sz;
    if (ex != 0)
      return ty == 0 && tgt[j] == ad;
    if (ty == 0 || (ty == 1 && w == 0))
      return 0;
    return ad <= lo + sz && lo <= ad + int'(a.data_bytes) - 1;
  endfunction
  initial
  begin
    void'($urandom(36));
    ci = '0;
    ci.real_mode = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      rd32(5'(i * 4));
      chk("reset", d, 0);
      chk("rresp ok", r, bkpt_pkg::RESP_OKAY);
    end
    rd32(5'h18);
    chk("rresp", r, bkpt_pkg::RESP_SLVERR);
    wr32(5'h02, 32'hffff_ffff);
    chk("bresp", r, bkpt_pkg::RESP_SLVERR);
    wr32(bkpt_pkg::OFF_STATUS, 32'hffff_ffff);
    chk("bresp ok", r, bkpt_pkg::RESP_OKAY);
    rd32(bkpt_pkg::OFF_STATUS);
    chk("sts mask", d, bkpt_pkg::STS_WMASK);
    wr32(bkpt_pkg::OFF_CONTROL, 32'hffff_ffff);
    rd32(bkpt_pkg::OFF_CONTROL);
    chk("ctl mask", d, bkpt_pkg::CTL_WMASK);
    $display("register test done");
    // Random sizes, types, enables and overlaps
    for (k = 0; k < 60; k++)
    begin
      ad = $urandom & 32'hffff_fff0;
      ctl = 0;
      for (i = 0; i < 4; i++)
      begin
        tgt[i] = ad + ($urandom & 7);
        t = tc[$urandom % 3];
        s = t == 0 ? 0 : tc[$urandom % 3];
        ctl |= ($urandom & 3) << 2 * i | t << 16 + 4 * i | s << 18 + 4 * i;
        wr32(5'(i * 4), tgt[i]);
      end
      wr32(bkpt_pkg::OFF_CONTROL, ctl);
      wr32(bkpt_pkg::OFF_STATUS, 0);
      ex = $urandom & 1;
      w = $urandom & 1;
      ad = ad + ($urandom & 7);
      a = '{ex[0], ad, 1'b0, !ex[0], w[0], ad, 4'(1 + $urandom % 4)};
      core_model_inst.step(a, ci, e);
      hits = 0;
      en = 0;
      for (i = 0; i < 4; i++)
        if (mhit(i))
        begin
          hits |= 1 << i;
          en |= (ctl >> 2 * i & 3) != 0;
        end
      chk("fault", e.fault, ex != 0 && en != 0);
      chk("trap", e.trap, ex == 0 && en != 0);
      rd32(bkpt_pkg::OFF_STATUS);
      if (en == 0)
        hits = 0;
      chk("hits", d, hits);
    end
    $display("match test done");
    // Task switch, then single step with flags kept
    wr32(bkpt_pkg::OFF_CONTROL, 32'h0000_03ff);
    wr32(bkpt_pkg::OFF_STATUS, 0);
    a = '0;
    c = ci;
    c.task_switch = 1'b1;
    c.task_trap_attr = 1'b1;
    core_model_inst.step(a, c, e);
    chk("ts trap", e.trap, 1);
    rd32(bkpt_pkg::OFF_CONTROL);
    chk("ts ctl", d, 32'h0000_02aa);
    c = ci;
    c.insn_end = 1'b1;
    c.flags = 32'h0000_0100;
    core_model_inst.step(a, c, e);
    chk("step", e.trap, 1);
    c.flags = 32'hffff_feff;
    core_model_inst.step(a, c, e);
    chk("no step", e.trap, 0);
    rd32(bkpt_pkg::OFF_STATUS);
    chk("step sts", d, 32'h0000_c000);
    $display("event test done");
    // Guarded, privileged and unprivileged core accesses
    wr32(bkpt_pkg::OFF_CONTROL, 32'h0000_2000);
    wr32(bkpt_pkg::OFF_STATUS, 0);
    c = ci;
    c.dbg_req = 1'b1;
    c.dbg_write = 1'b1;
    c.dbg_wdata = ~tgt[0];
    core_model_inst.step(a, c, e);
    chk("guard", {e.fault, e.dbg_ack}, 2'b10);
    rd32(bkpt_pkg::OFF_CONTROL);
    chk("guard ctl", d, 0);
    rd32(bkpt_pkg::OFF_STATUS);
    chk("guard sts", d, 32'h0000_2000);
    c.dbg_write = 1'b0;
    core_model_inst.step(a, c, e);
    chk("core rd", e.dbg_rdata, tgt[0]);
    c.cpl = 2'h3;
    c.real_mode = 1'b0;
    core_model_inst.step(a, c, e);
    chk("denied", e.dbg_denied, 1);
    wr32(bkpt_pkg::OFF_CONTROL, 32'h0000_2000);
    c = ci;
    c.handler_entry = 1'b1;
    core_model_inst.step(a, c, e);
    rd32(bkpt_pkg::OFF_CONTROL);
    chk("entry ctl", d, 0);
    // Resume flag over an enabled execution hit
    wr32(bkpt_pkg::OFF_CONTROL, 32'h0000_0001);
    a = '{1'b1, tgt[0], 1'b1, 1'b0, 1'b0, 32'h0, 4'h0};
    core_model_inst.step(a, ci, e);
    chk("resume", e.fault, 0);
    $display("guard test done");
    give_verdict();
  end
endmodule
